/* File: rtl/coil_voltage_capture.sv */
// one quadrant result: catches the averaged code at its phase
`timescale 1ns/10ps
module coil_voltage_capture
  import coil_voltage_pkg::*;
#(
  parameter logic [PHASE_W-1:0] TARGET_PHASE = PHASE_90
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // converter result stream
  input wire logic sample_valid,
  input wire logic [PHASE_W-1:0] sample_phase,
  input wire logic [CV_W-1:0] sample_code,
  // held result
  output logic [CV_W-1:0] value_reg
);

  // code is already referred to 28 V full scale, stored unchanged
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      value_reg <= CV_RESET;
    end else if (sample_valid && sample_phase == TARGET_PHASE) begin
      value_reg <= sample_code;
    end
  end

endmodule : coil_voltage_capture

/* File: rtl/coil_voltage_pkg.sv */
// constants for the coil voltage quadrant result registers
package coil_voltage_pkg;

  // register port
  localparam int ADDR_W = 6;
  localparam int WORD_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_CV_90 = 6'h0a;
  localparam logic [ADDR_W-1:0] ADDR_CV_180 = 6'h0b;

  // result word layout
  localparam int CV_W = 10;
  localparam int CV_LSB = 1;
  localparam int CV_MSB = 10;
  localparam int RSV_LSB = 11;
  localparam int RSV_MSB = 15;
  localparam int PARITY_BIT = 0;
  localparam logic [RSV_MSB-RSV_LSB:0] RSV_VALUE = 5'h00;

  // converter side
  localparam int PHASE_W = 6;
  localparam logic [PHASE_W-1:0] PHASE_90 = 6'h10;
  localparam logic [PHASE_W-1:0] PHASE_180 = 6'h20;
  localparam logic [CV_W-1:0] CV_RESET = 10'h000;
  localparam logic [CV_W-1:0] CV_FULL_SCALE = 10'h3ff;
  localparam int CV_FULL_SCALE_MV = 28000;

  // parity sense: whole word carries an odd number of ones
  localparam logic PARITY_ODD = 1'b1;

endpackage : coil_voltage_pkg

/* File: rtl/coil_voltage_quadrant_regs.sv */
// 90 and 180 degree coil voltage result registers with read port
`timescale 1ns/10ps

module coil_voltage_quadrant_regs
  import coil_voltage_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // averaged results from the converter
  input wire logic sample_valid,
  input wire logic [PHASE_W-1:0] sample_phase,
  input wire logic [CV_W-1:0] sample_code,
  // register read request from the serial interface
  input wire logic rd_req,
  input wire logic [ADDR_W-1:0] rd_addr,
  // read answer
  output logic [WORD_W-1:0] rd_data_reg,
  output logic rd_ack_reg,
  output logic rd_mapped_reg
);

  logic [CV_W-1:0] cv_value [2];
  logic [WORD_W-1:0] word_next;
  logic mapped_next;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_quadrant
      coil_voltage_capture #(
        .TARGET_PHASE(gi == 0 ? PHASE_90 : PHASE_180)
      ) u_capture (
        .mclk(mclk),
        .reset(reset),
        .sample_valid(sample_valid),
        .sample_phase(sample_phase),
        .sample_code(sample_code),
        .value_reg(cv_value[gi])
      );
    end
  endgenerate

  // word assembly; unmapped addresses answer an all-zero payload
  always_comb begin
    word_next = '0;
    mapped_next = 1'b0;
    if (rd_addr == ADDR_CV_90) begin
      word_next[CV_MSB:CV_LSB] = cv_value[0];
      mapped_next = 1'b1;
    end else if (rd_addr == ADDR_CV_180) begin
      word_next[CV_MSB:CV_LSB] = cv_value[1];
      mapped_next = 1'b1;
    end
    word_next[RSV_MSB:RSV_LSB] = RSV_VALUE;
    // parity taken last so it covers the final payload
    word_next[PARITY_BIT] = PARITY_ODD ^ (^word_next[WORD_W-1:1]);
  end

  // answer registered one edge after the request
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_data_reg <= '0;
      rd_mapped_reg <= 1'b0;
    end else if (rd_req) begin
      rd_data_reg <= word_next;
      rd_mapped_reg <= mapped_next;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_ack_reg <= 1'b0;
    end else begin
      rd_ack_reg <= rd_req;
    end
  end

  // checks
  logic hit_90;
  logic hit_180;
  assign hit_90 = sample_valid && sample_phase == PHASE_90;
  assign hit_180 = sample_valid && sample_phase == PHASE_180;

  property p_capture_90;
    @(posedge mclk) disable iff (reset)
      hit_90 |=> cv_value[0] == $past(sample_code);
  endproperty
  a_capture_90: assert property (p_capture_90)
    else $error("90 degree word missed its phase 16 sample");

  property p_capture_180;
    @(posedge mclk) disable iff (reset)
      !hit_180 |=> $stable(cv_value[1]);
  endproperty
  a_capture_180: assert property (p_capture_180)
    else $error("180 degree word changed outside phase 32");

  property p_read_90;
    @(posedge mclk) disable iff (reset)
      (rd_req && rd_addr == ADDR_CV_90 && !hit_90) ##1 !hit_90
        |-> rd_ack_reg && rd_mapped_reg
            && rd_data_reg[CV_MSB:CV_LSB] == cv_value[0];
  endproperty
  a_read_90: assert property (p_read_90)
    else $error("90 degree read returned wrong value");

  property p_full_scale;
    @(posedge mclk) disable iff (reset)
      rd_req && rd_addr == ADDR_CV_180 && cv_value[1] == CV_FULL_SCALE
        |=> rd_data_reg[CV_MSB:CV_LSB] == CV_FULL_SCALE;
  endproperty
  a_full_scale: assert property (p_full_scale)
    else $error("full scale code not returned intact");

  property p_reserved_zero;
    @(posedge mclk) disable iff (reset)
      rd_ack_reg |-> rd_data_reg[RSV_MSB:RSV_LSB] == RSV_VALUE;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits of result word not zero");

  property p_reset_default;
    @(posedge mclk) disable iff (reset)
      $past(reset) |-> cv_value[1] == CV_RESET && cv_value[0] == CV_RESET;
  endproperty
  a_reset_default: assert property (p_reset_default)
    else $error("result value not zero after reset");

  property p_parity;
    @(posedge mclk) disable iff (reset)
      rd_ack_reg |-> (^rd_data_reg) == PARITY_ODD;
  endproperty
  a_parity: assert property (p_parity)
    else $error("read word parity wrong");

  property p_ack_timing;
    @(posedge mclk) disable iff (reset)
      rd_req |=> rd_ack_reg;
  endproperty
  a_ack_timing: assert property (p_ack_timing)
    else $error("read answer not one cycle after request");

  property p_unmapped;
    @(posedge mclk) disable iff (reset)
      rd_req && rd_addr != ADDR_CV_90 && rd_addr != ADDR_CV_180
        |=> !rd_mapped_reg && rd_data_reg[WORD_W-1:1] == '0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned a payload");

  // capture side: each word moves only on its own phase
  property p_hold_90;
    @(posedge mclk) disable iff (reset)
      !hit_90 |=> $stable(cv_value[0]);
  endproperty
  a_hold_90: assert property (p_hold_90)
    else $error("90 degree word changed outside phase 16");

  property p_load_180;
    @(posedge mclk) disable iff (reset)
      hit_180 |=> cv_value[1] == $past(sample_code);
  endproperty
  a_load_180: assert property (p_load_180)
    else $error("180 degree word missed its phase 32 sample");

  // read side
  property p_read_180;
    @(posedge mclk) disable iff (reset)
      rd_req && rd_addr == ADDR_CV_180
        |=> rd_ack_reg && rd_mapped_reg
            && rd_data_reg[CV_MSB:CV_LSB] == $past(cv_value[1]);
  endproperty
  a_read_180: assert property (p_read_180)
    else $error("180 degree read returned wrong value");

  // ack is a one-cycle echo, never a stray pulse
  property p_ack_single;
    @(posedge mclk) disable iff (reset)
      !rd_req |=> !rd_ack_reg;
  endproperty
  a_ack_single: assert property (p_ack_single)
    else $error("read answer without a request");

  // answer stands until the next taken request
  property p_data_hold;
    @(posedge mclk) disable iff (reset)
      !rd_req |=> $stable(rd_data_reg) && $stable(rd_mapped_reg);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("read answer changed without a request");

  property p_reset_outputs;
    @(posedge mclk) disable iff (reset)
      $past(reset)
        |-> !rd_ack_reg && !rd_mapped_reg && rd_data_reg == '0;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs)
    else $error("read port not cleared by reset");

  // zero payload must still carry a set parity bit under odd sense
  property p_zero_word;
    @(posedge mclk) disable iff (reset)
      rd_ack_reg && rd_data_reg[WORD_W-1:1] == '0
        |-> rd_data_reg[PARITY_BIT] == PARITY_ODD;
  endproperty
  a_zero_word: assert property (p_zero_word)
    else $error("all-zero word carries wrong parity");

  c_read_90: cover property (@(posedge mclk) disable iff (reset)
    hit_90 ##1 rd_req && rd_addr == ADDR_CV_90);
  c_read_180: cover property (@(posedge mclk) disable iff (reset)
    hit_180 ##1 rd_req && rd_addr == ADDR_CV_180);
  c_unmapped: cover property (@(posedge mclk) disable iff (reset)
    rd_ack_reg && !rd_mapped_reg);
  c_full_scale: cover property (@(posedge mclk) disable iff (reset)
    rd_ack_reg && rd_data_reg[CV_MSB:CV_LSB] == CV_FULL_SCALE);
  // read racing a matching sample must see the old value
  c_same_cycle: cover property (@(posedge mclk) disable iff (reset)
    hit_90 && rd_req && rd_addr == ADDR_CV_90);

endmodule : coil_voltage_quadrant_regs

/* File: verif/host_reader.sv */
// host model issuing register reads over the read port
`timescale 1ns/10ps
module host_reader
  import coil_voltage_pkg::*;
(
  // clock
  input wire logic mclk,
  // read request
  output logic rd_req,
  output logic [ADDR_W-1:0] rd_addr
);
  initial begin
    rd_req = 1'b0;
    rd_addr = '0;
  end
  task automatic read(input logic [ADDR_W-1:0] a);
    @(posedge mclk) #1;
    rd_req = 1'b1;
    rd_addr = a;
    @(posedge mclk) #1;
    rd_req = 1'b0;
    // released address is driven to the complement of the requested one
    rd_addr = ~a;
  endtask : read
endmodule : host_reader

/* File: verif/tb_coil_voltage_quadrant_regs.sv */
// self-checking bench for the quadrant result registers
`timescale 1ns/10ps
module tb_coil_voltage_quadrant_regs;
  import coil_voltage_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic sample_valid = 1'b0;
  logic [PHASE_W-1:0] sample_phase = '0;
  logic [CV_W-1:0] sample_code = '0;
  logic rd_req, rd_ack_reg, rd_mapped_reg;
  logic [ADDR_W-1:0] rd_addr;
  logic [WORD_W-1:0] rd_data_reg;
  logic [CV_W-1:0] cv90 = '0;
  logic [CV_W-1:0] cv180 = '0;
  logic [WORD_W:0] notes[$];
  int mismatches = 0;
  int tests_run = 0;
  always #20 mclk = ~mclk;
  coil_voltage_quadrant_regs i_coil_voltage_quadrant_regs (.mclk(mclk),
    .reset(reset), .sample_valid(sample_valid), .sample_phase(sample_phase),
    .sample_code(sample_code), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data_reg(rd_data_reg), .rd_ack_reg(rd_ack_reg),
    .rd_mapped_reg(rd_mapped_reg));
  host_reader i_host_reader (.mclk(mclk), .rd_req(rd_req), .rd_addr(rd_addr));
  task automatic check(input string n, input logic [WORD_W:0] s, e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask : check
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic rd(input logic [ADDR_W-1:0] a);
    logic [CV_W-1:0] v;
    logic m;
    m = (a == ADDR_CV_90) || (a == ADDR_CV_180);
    v = (a == ADDR_CV_90) ? cv90 : (a == ADDR_CV_180) ? cv180 : '0;
    // odd ones over whole word
    notes.push_back({m, RSV_VALUE, v, ~^v});
    i_host_reader.read(a);
  endtask : rd
  task automatic smp(input logic [PHASE_W-1:0] p, input logic [CV_W-1:0] c);
    @(posedge mclk) #1;
    sample_valid = 1'b1;
    sample_phase = p;
    sample_code = c;
    @(posedge mclk) #1;
    sample_valid = 1'b0;
    sample_phase = ~p;
    if (p == PHASE_90) cv90 = c;
    if (p == PHASE_180) cv180 = c;
  endtask : smp
  always @(negedge mclk) begin
    if (rd_ack_reg === 1'b1) begin
      if (notes.size() == 0) check("extra ack", 17'h1, 17'h0);
      else check("word", {rd_mapped_reg, rd_data_reg}, notes.pop_front());
    end
  end
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    results();
  end
  initial begin
    void'($urandom(32'ha99233f9));
    repeat (8) @(posedge mclk);
    #1 reset = 1'b0;
    rd(ADDR_CV_90);
    rd(ADDR_CV_180);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      smp(PHASE_90, CV_W'($urandom));
      smp(PHASE_180, CV_W'($urandom));
      // odd phases never match a quadrant
      smp(PHASE_W'($urandom) | 6'h01, CV_W'($urandom));
      rd(ADDR_CV_90);
      rd(ADDR_CV_180);
      rd(ADDR_W'($urandom));
    end
    $display("test random capture done");
    smp(PHASE_180, CV_FULL_SCALE);
    smp(PHASE_90, CV_RESET);
    rd(ADDR_CV_180);
    rd(ADDR_CV_90);
    rd(6'h0c);
    // read in the sample's own cycle sees the old value
    fork
      smp(PHASE_90, CV_FULL_SCALE);
      rd(ADDR_CV_90);
    join
    rd(ADDR_CV_90);
    $display("test scale and unmapped done");
    @(posedge mclk) #1;
    reset = 1'b1;
    cv90 = '0;
    cv180 = '0;
    repeat (2) @(posedge mclk);
    #1 reset = 1'b0;
    rd(ADDR_CV_180);
    rd(ADDR_CV_90);
    for (int i = 0; i < 20 && notes.size() > 0; i++) @(posedge mclk);
    if (notes.size() > 0) check("missing ack", 17'h1, 17'h0);
    $display("test second reset done");
    results();
  end
endmodule : tb_coil_voltage_quadrant_regs
